/* File: common/adcc_map.vh */
// register map, field positions, reset values and timing counts
// assumes inclusion by the converter control design files
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH

// register offsets on the plain register port
`define ADCC_A_CTRL      3'h0
`define ADCC_A_CLKSRC    3'h1
`define ADCC_A_RHIGH     3'h2
`define ADCC_A_RLOW      3'h3
`define ADCC_A_INTC      3'h4

// converter_control_reg field positions
`define ADCC_B_START     7
`define ADCC_B_BUSY      6
`define ADCC_B_PCR_HI    5
`define ADCC_B_PCR_LO    3
`define ADCC_B_ACS_HI    2
`define ADCC_B_ACS_LO    0

// interrupt register field positions
`define ADCC_B_IRQF      0
`define ADCC_B_IRQE      1

// reset values
`define ADCC_R_PCR       3'h0
`define ADCC_R_ACS       3'h0
`define ADCC_R_CLKSRC    3'h0
`define ADCC_R_BUSY      1'b1

// conversion length in converter clock periods per resolution
`define ADCC_CONV_TAD_8  7'h40
`define ADCC_CONV_TAD_9  7'h4c
`define ADCC_CONV_TAD_12 7'h50

// divider terminal counts (ratio minus one) per select code
`define ADCC_DIV_100     7'h00
`define ADCC_DIV_000     7'h01
`define ADCC_DIV_101     7'h03
`define ADCC_DIV_001     7'h07
`define ADCC_DIV_110     7'h0f
`define ADCC_DIV_010     7'h1f
`define ADCC_DIV_011     7'h3f
`define ADCC_DIV_111     7'h7f

`endif

/* File: hw/adcc_clkdiv.v */
// converter clock divider: one-cycle tick per converter clock period
// assumes one system clock and a synchronous clear from the controller
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.vh"

module adcc_clkdiv (
    input  wire       mclk_i,
    input  wire       rst_i,
    input  wire       clr_i,
    input  wire [2:0] sel_i,
    output wire       tick_o
);

// ----------------------------------------
// divide ratio lookup
// ----------------------------------------
function [6:0] div_last;
    input [2:0] sel;
    begin
        case (sel)
            3'h4:    div_last = `ADCC_DIV_100;
            3'h0:    div_last = `ADCC_DIV_000;
            3'h5:    div_last = `ADCC_DIV_101;
            3'h1:    div_last = `ADCC_DIV_001;
            3'h6:    div_last = `ADCC_DIV_110;
            3'h2:    div_last = `ADCC_DIV_010;
            3'h3:    div_last = `ADCC_DIV_011;
            default: div_last = `ADCC_DIV_111;
        endcase
    end
endfunction

// ----------------------------------------
// counter
// ----------------------------------------
reg  [6:0] cnt_ff;
wire       wrap;

assign wrap   = (cnt_ff >= div_last(sel_i));
assign tick_o = wrap & ~clr_i;

always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        cnt_ff <= 7'h00;
    end else if (clr_i || wrap) begin
        cnt_ff <= 7'h00;
    end else begin
        cnt_ff <= cnt_ff + 7'h01;
    end
end

endmodule
`default_nettype wire

/* File: hw/adcc_sar.v */
// successive approximation sequencer: sample phase then one bit per tick
// assumes a comparator level already synchronised to the system clock
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.vh"

module adcc_sar #(
    parameter RES_BITS = 12
) (
    input  wire                mclk_i,
    input  wire                rst_i,
    input  wire                clr_i,
    input  wire                go_i,
    input  wire                tick_i,
    input  wire                cmp_i,
    output wire [RES_BITS-1:0] trial_o,
    output reg                 done_o,
    output reg  [RES_BITS-1:0] result_o
);

localparam ST_IDLE = 2'b00;
localparam ST_SAMP = 2'b01;
localparam ST_CONV = 2'b10;

// ----------------------------------------
// conversion length
// ----------------------------------------
function [6:0] conv_len;
    input integer res;
    begin
        if (res == 8) begin
            conv_len = `ADCC_CONV_TAD_8;
        end else if (res == 9) begin
            conv_len = `ADCC_CONV_TAD_9;
        end else begin
            conv_len = `ADCC_CONV_TAD_12;
        end
    end
endfunction

localparam [6:0] SAMP_LAST = conv_len(RES_BITS) - RES_BITS[6:0] - 7'h01;
localparam [RES_BITS-1:0] MSB = {1'b1, {(RES_BITS-1){1'b0}}};
localparam [RES_BITS-1:0] ONE = {{(RES_BITS-1){1'b0}}, 1'b1};

// ----------------------------------------
// sequencer
// ----------------------------------------
reg  [1:0]          st_ff;
reg  [6:0]          cnt_ff;
reg  [RES_BITS-1:0] trial_ff;
reg  [RES_BITS-1:0] mask_ff;
wire [RES_BITS-1:0] kept;

assign trial_o = trial_ff;
assign kept    = cmp_i ? trial_ff : (trial_ff & ~mask_ff);

always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        st_ff    <= ST_IDLE;
        cnt_ff   <= 7'h00;
        trial_ff <= {RES_BITS{1'b0}};
        mask_ff  <= {RES_BITS{1'b0}};
        done_o   <= 1'b0;
        result_o <= {RES_BITS{1'b0}};
    end else begin
        done_o <= 1'b0;
        if (clr_i) begin
            st_ff    <= ST_IDLE;
            trial_ff <= {RES_BITS{1'b0}};
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    if (go_i) begin
                        st_ff    <= ST_SAMP;
                        cnt_ff   <= 7'h00;
                        trial_ff <= {RES_BITS{1'b0}};
                    end
                end
                ST_SAMP: begin
                    if (tick_i) begin
                        cnt_ff <= cnt_ff + 7'h01;
                        if (cnt_ff == SAMP_LAST) begin
                            st_ff    <= ST_CONV;
                            trial_ff <= MSB;
                            mask_ff  <= MSB;
                        end
                    end
                end
                ST_CONV: begin
                    if (tick_i) begin
                        trial_ff <= kept | (mask_ff >> 1);
                        mask_ff  <= mask_ff >> 1;
                        if (mask_ff == ONE) begin
                            st_ff    <= ST_IDLE;
                            done_o   <= 1'b1;
                            result_o <= kept;
                        end
                    end
                end
                default: begin
                    st_ff <= ST_IDLE;
                end
            endcase
        end
    end
end

endmodule
`default_nettype wire

/* File: hw/adcc_ctrl.v */
// converter control top: registers, start protocol, results, interrupt
// assumes an analog mux, trial DAC and comparator outside this logic
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.vh"

module adcc_ctrl #(
    parameter RES_BITS = 12
) (
    input  wire                mclk_i,
    input  wire                rst_i,
    input  wire [2:0]          addr_i,
    input  wire [7:0]          wdata_i,
    input  wire                wr_i,
    input  wire                rd_i,
    output wire [7:0]          rdata_o,
    input  wire                cmp_i,
    output wire [1:0]          ch_sel_o,
    output wire [3:0]          analog_en_o,
    output wire                adc_pd_o,
    output wire                conv_rst_o,
    output wire [RES_BITS-1:0] dac_o,
    output wire                irq_o
);

// ----------------------------------------
// state
// ----------------------------------------
reg                 start_ff;
reg                 busy_ff;
reg  [2:0]          pcr_ff;
reg  [2:0]          acs_ff;
reg  [2:0]          adcs_ff;
reg  [RES_BITS-1:0] res_ff;
reg                 irqf_ff;
reg                 irqe_ff;
reg                 irq_ff;
reg  [7:0]          rdata_ff;
reg                 cmp_m_ff;
reg                 cmp_s_ff;
reg  [3:0]          aen_ff;
reg                 pd_ff;
reg                 go_ff;

reg                 nxt_start;
reg                 nxt_busy;
reg  [2:0]          nxt_pcr;
reg  [2:0]          nxt_acs;
reg  [2:0]          nxt_adcs;
reg                 nxt_irqf;
reg                 nxt_irqe;
reg                 nxt_go;
reg  [7:0]          nxt_rdata;

wire                wr_ctrl;
wire                wr_clk;
wire                wr_intc;
wire                conv_clr;
wire                tick;
wire                sar_done;
wire [RES_BITS-1:0] sar_res;
wire [15:0]         res_left;

// ----------------------------------------
// pin configuration decode
// ----------------------------------------
function [3:0] pin_map;
    input [2:0] pcr;
    begin
        if (pcr[2]) begin
            pin_map = 4'hf;
        end else if (pcr == 3'h3) begin
            pin_map = 4'h7;
        end else if (pcr == 3'h2) begin
            pin_map = 4'h3;
        end else if (pcr == 3'h1) begin
            pin_map = 4'h1;
        end else begin
            pin_map = 4'h0;
        end
    end
endfunction

// ----------------------------------------
// bus decode
// ----------------------------------------
assign wr_ctrl = wr_i && (addr_i == `ADCC_A_CTRL);
assign wr_clk  = wr_i && (addr_i == `ADCC_A_CLKSRC);
assign wr_intc = wr_i && (addr_i == `ADCC_A_INTC);

// ----------------------------------------
// next-state logic
// ----------------------------------------
always @* begin
    nxt_start = start_ff;
    nxt_pcr   = pcr_ff;
    nxt_acs   = acs_ff;
    nxt_adcs  = adcs_ff;
    nxt_irqe  = irqe_ff;
    nxt_irqf  = irqf_ff;
    nxt_go    = 1'b0;
    if (wr_ctrl) begin
        nxt_start = wdata_i[`ADCC_B_START];
        nxt_pcr   = wdata_i[`ADCC_B_PCR_HI:`ADCC_B_PCR_LO];
        nxt_acs   = wdata_i[`ADCC_B_ACS_HI:`ADCC_B_ACS_LO];
        // falling start after a rise launches one conversion unless the pin configuration is zero
        nxt_go    = start_ff && !wdata_i[`ADCC_B_START]
                    && (nxt_pcr != 3'h0);
    end
    if (wr_clk) begin
        nxt_adcs = wdata_i[2:0];
    end
    if (wr_intc) begin
        nxt_irqe = wdata_i[`ADCC_B_IRQE];
        if (!wdata_i[`ADCC_B_IRQF]) begin
            nxt_irqf = 1'b0;
        end
    end
    if (sar_done && !start_ff) begin
        nxt_irqf = 1'b1;
    end
    if (nxt_start) begin
        nxt_busy = 1'b1;
    end else if (sar_done && !start_ff) begin
        nxt_busy = 1'b0;
    end else begin
        nxt_busy = busy_ff;
    end
end

// ----------------------------------------
// result alignment and read mux
// ----------------------------------------
// left-align so high byte is the top eight result bits
assign res_left = {res_ff, {(16-RES_BITS){1'b0}}};

always @* begin
    nxt_rdata = 8'h00;
    if (rd_i) begin
        if (addr_i == `ADCC_A_CTRL) begin
            nxt_rdata = {start_ff, busy_ff, pcr_ff, acs_ff};
        end else if (addr_i == `ADCC_A_CLKSRC) begin
            nxt_rdata = {5'h00, adcs_ff};
        end else if (addr_i == `ADCC_A_RHIGH) begin
            nxt_rdata = res_left[15:8];
        end else if (addr_i == `ADCC_A_RLOW) begin
            nxt_rdata = (RES_BITS > 8) ? res_left[7:0] : 8'h00;
        end else if (addr_i == `ADCC_A_INTC) begin
            nxt_rdata = {6'h00, irqe_ff, irqf_ff};
        end else begin
            nxt_rdata = 8'h00;
        end
    end
end

// ----------------------------------------
// registers
// ----------------------------------------
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        start_ff <= 1'b0;
        busy_ff  <= `ADCC_R_BUSY;
        pcr_ff   <= `ADCC_R_PCR;
        acs_ff   <= `ADCC_R_ACS;
        adcs_ff  <= `ADCC_R_CLKSRC;
        res_ff   <= {RES_BITS{1'b0}};
        irqf_ff  <= 1'b0;
        irqe_ff  <= 1'b0;
        irq_ff   <= 1'b0;
        rdata_ff <= 8'h00;
        aen_ff   <= 4'h0;
        pd_ff    <= 1'b1;
        go_ff    <= 1'b0;
    end else begin
        start_ff <= nxt_start;
        busy_ff  <= nxt_busy;
        pcr_ff   <= nxt_pcr;
        acs_ff   <= nxt_acs;
        adcs_ff  <= nxt_adcs;
        irqf_ff  <= nxt_irqf;
        irqe_ff  <= nxt_irqe;
        irq_ff   <= nxt_irqf & nxt_irqe;
        rdata_ff <= nxt_rdata;
        aen_ff   <= pin_map(nxt_pcr);
        pd_ff    <= (nxt_pcr == 3'h0);
        go_ff    <= nxt_go;
        if (sar_done && !start_ff) begin
            res_ff <= sar_res;
        end
    end
end

// ----------------------------------------
// comparator synchroniser
// ----------------------------------------
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        cmp_m_ff <= 1'b0;
        cmp_s_ff <= 1'b0;
    end else begin
        cmp_m_ff <= cmp_i;
        cmp_s_ff <= cmp_m_ff;
    end
end

// ----------------------------------------
// converter clock and sequencer
// ----------------------------------------
// start held high or power-down holds the converter in reset
assign conv_clr = start_ff | pd_ff;

adcc_clkdiv u_div (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .clr_i  (conv_clr),
    .sel_i  (adcs_ff),
    .tick_o (tick)
);

adcc_sar #(
    .RES_BITS (RES_BITS)
) u_sar (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .clr_i    (conv_clr),
    .go_i     (go_ff),
    .tick_i   (tick),
    .cmp_i    (cmp_s_ff),
    .trial_o  (dac_o),
    .done_o   (sar_done),
    .result_o (sar_res)
);

// ----------------------------------------
// outputs
// ----------------------------------------
// channel msb is kept zero by software; only two bits reach the mux
assign ch_sel_o    = acs_ff[1:0];
assign analog_en_o = aen_ff;
assign adc_pd_o    = pd_ff;
assign conv_rst_o  = conv_clr;
assign rdata_o     = rdata_ff;
assign irq_o       = irq_ff;

endmodule
`default_nettype wire

/* File: sim/adcc_ctrl_chk.sv */
// checker: port timing relations of the converter control block
// assumes a bind onto adcc_ctrl from the testbench top file
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.vh"

module adcc_ctrl_chk #(
    parameter RES_BITS = 12
) (
    input wire logic                mclk_i,
    input wire logic                rst_i,
    input wire logic [2:0]          addr_i,
    input wire logic [7:0]          wdata_i,
    input wire logic                wr_i,
    input wire logic                rd_i,
    input wire logic [7:0]          rdata_o,
    input wire logic                cmp_i,
    input wire logic [1:0]          ch_sel_o,
    input wire logic [3:0]          analog_en_o,
    input wire logic                adc_pd_o,
    input wire logic                conv_rst_o,
    input wire logic [RES_BITS-1:0] dac_o,
    input wire logic                irq_o
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    wire wc = wr_i && addr_i == `ADCC_A_CTRL;
    wire wi = wr_i && addr_i == `ADCC_A_INTC;

    rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not zero outside read slot");
    unmapped_rd_a: assert property (
        rd_i && addr_i > `ADCC_A_INTC |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    pd_cfg_a: assert property (
        wc && wdata_i[5:3] == 3'h0 |=> adc_pd_o && analog_en_o == 4'h0)
        else $error("pin config zero not powered down");
    all_analog_a: assert property (
        wc && wdata_i[5] |=> !adc_pd_o && analog_en_o == 4'hf)
        else $error("pin config high not all analog");
    low_pins_a: assert property (
        wc && !wdata_i[5] && wdata_i[4:3] != 2'h0 |=>
        analog_en_o == (4'h1 << $past(wdata_i[4:3])) - 4'h1)
        else $error("partial pin enable wrong");
    chan_route_a: assert property (
        wc |=> ch_sel_o == $past(wdata_i[1:0]))
        else $error("channel not routed");
    start_hold_a: assert property (wc && wdata_i[7] |=> conv_rst_o)
        else $error("converter not held in reset");
    busy_force_a: assert property (
        wc && wdata_i[7] ##1 !wc ##1 (rd_i && addr_i == `ADCC_A_CTRL) |=>
        rdata_o[7:6] == 2'b11)
        else $error("busy not forced while start high");
    irq_mask_a: assert property (
        wi && !wdata_i[1] ##1 !wi |=> !irq_o)
        else $error("interrupt seen while disabled");

    cover property ($rose(irq_o));
    cover property (wc && wdata_i[7]);
    cover property (rd_i && addr_i == `ADCC_A_RHIGH);
endmodule
`default_nettype wire

/* File: sim/adcc_afe_model.sv */
// model of analog mux and comparator facing the converter control
// assumes a 12-bit trial value; inputs given as codes per channel
`timescale 1ns/1ps
`default_nettype none

module adcc_afe_model (
    input  wire logic        mclk_i,
    input  wire logic [1:0]  ch_sel_i,
    input  wire logic [3:0]  analog_en_i,
    input  wire logic        adc_pd_i,
    input  wire logic [11:0] dac_i,
    input  wire logic [47:0] vin_i,
    output logic             cmp_o
);
    // ----------------------------------------
    // comparator
    // ----------------------------------------
    logic        junk_ff = 1'b0;
    logic [11:0] lvl;

    // no valid input: output wanders every cycle
    always @(posedge mclk_i) junk_ff <= ~junk_ff;

    // level sits half a step above its code
    assign lvl = vin_i[ch_sel_i*12 +: 12];
    assign cmp_o = (adc_pd_i || !analog_en_i[ch_sel_i]) ? junk_ff :
                   ({lvl, 1'b1} > {dac_i, 1'b0});
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// testbench: register tasks and conversion sequences for adcc_ctrl
// assumes afe models on the comparator side, 12-bit build beside 8 and 9
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.vh"

module testbench;
    logic        mclk_i;
    logic        rst_i;
    logic [2:0]  addr_i;
    logic [7:0]  wdata_i;
    logic        wr_i;
    logic        rd_i;
    wire  [7:0]  rdata_o;
    wire         cmp_i;
    wire  [1:0]  ch_sel_o;
    wire  [3:0]  analog_en_o;
    wire         adc_pd_o;
    wire         conv_rst_o;
    wire  [11:0] dac_o;
    wire         irq_o;
    logic [47:0] vin;
    logic [7:0]  d;
    integer      fail_count;
    integer      checks_done;
    integer      cyc;
    integer      t0;
    integer      i;
    wire  [7:0]  rdata8;
    wire  [7:0]  rdata9;
    wire         cmp8;
    wire         cmp9;
    wire  [1:0]  ch8;
    wire  [1:0]  ch9;
    wire  [3:0]  aen8;
    wire  [3:0]  aen9;
    wire         pd8;
    wire         pd9;
    wire  [7:0]  dac8;
    wire  [8:0]  dac9;
    logic [7:0]  d8;
    logic [7:0]  d9;
    integer      t8;
    integer      t9;

    adcc_ctrl #(.RES_BITS(12)) u_adcc_ctrl (
        .mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .cmp_i, .ch_sel_o, .analog_en_o, .adc_pd_o, .conv_rst_o,
        .dac_o, .irq_o);

    adcc_afe_model u_adcc_afe_model (
        .mclk_i, .ch_sel_i(ch_sel_o), .analog_en_i(analog_en_o),
        .adc_pd_i(adc_pd_o), .dac_i(dac_o), .vin_i(vin), .cmp_o(cmp_i));

    // narrower builds share the bus; their trial values sit left-aligned
    adcc_ctrl #(.RES_BITS(8)) u_adcc_ctrl_r8 (
        .mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o(rdata8),
        .cmp_i(cmp8), .ch_sel_o(ch8), .analog_en_o(aen8), .adc_pd_o(pd8),
        .conv_rst_o(), .dac_o(dac8), .irq_o());

    adcc_afe_model u_adcc_afe_model_r8 (
        .mclk_i, .ch_sel_i(ch8), .analog_en_i(aen8), .adc_pd_i(pd8),
        .dac_i({dac8, 4'h0}), .vin_i(vin), .cmp_o(cmp8));

    adcc_ctrl #(.RES_BITS(9)) u_adcc_ctrl_r9 (
        .mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o(rdata9),
        .cmp_i(cmp9), .ch_sel_o(ch9), .analog_en_o(aen9), .adc_pd_o(pd9),
        .conv_rst_o(), .dac_o(dac9), .irq_o());

    adcc_afe_model u_adcc_afe_model_r9 (
        .mclk_i, .ch_sel_i(ch9), .analog_en_i(aen9), .adc_pd_i(pd9),
        .dac_i({dac9, 3'h0}), .vin_i(vin), .cmp_o(cmp9));

    // ----------------------------------------
    // clock, cycle count, watchdog
    // ----------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) cyc <= cyc + 1;
    initial begin
        #500000;
        fail_count++;
        results;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        v = rdata_o;
        d8 = rdata8;
        d9 = rdata9;
    endtask
    task automatic rchk(input string nm, input logic [2:0] a,
                        input logic [7:0] e);
        rd(a, d);
        chk(nm, {8'h00, e}, {8'h00, d});
    endtask
    task automatic conv(input logic [1:0] ch, input logic ien);
        logic [11:0] v;
        integer      n;
        v = vin[ch*12 +: 12];
        wr(`ADCC_A_CTRL, 8'ha0 | {6'h0, ch});
        @(negedge mclk_i);
        chk("conv_rst", 16'h1, {15'h0, conv_rst_o});
        rchk("busy_hold", `ADCC_A_CTRL, 8'he0 | {6'h0, ch});
        wr(`ADCC_A_CTRL, 8'h20 | {6'h0, ch});
        t0 = cyc;
        t8 = cyc;
        t9 = cyc;
        d = 8'h40;
        // local count: the caller's loop index must survive the poll
        for (n = 0; n < 200 && d[6]; n++) begin
            rd(`ADCC_A_CTRL, d);
            if (d8[6]) t8 = cyc;
            if (d9[6]) t9 = cyc;
        end
        chk("conv_len", 16'h1, {15'h0, (cyc - t0) >= 318 &&
            (cyc - t0) <= 334});
        chk("conv_len8", 16'h1, {15'h0, (t8 - t0) >= 254 &&
            (t8 - t0) <= 270});
        chk("conv_len9", 16'h1, {15'h0, (t9 - t0) >= 302 &&
            (t9 - t0) <= 318});
        chk("busy_clr", {8'h0, 8'h20 | {6'h0, ch}}, {8'h0, d});
        rchk("res_hi", `ADCC_A_RHIGH, v[11:4]);
        chk("res8", {8'h0, v[11:4]}, {8'h0, d8});
        chk("res9_hi", {8'h0, v[11:4]}, {8'h0, d9});
        rchk("res_lo", `ADCC_A_RLOW, {v[3:0], 4'h0});
        chk("res8_lo", 16'h0, {8'h0, d8});
        chk("res9_lo", {8'h0, v[3], 7'h0}, {8'h0, d9});
        chk("irq", {15'h0, ien}, {15'h0, irq_o});
        rchk("flag", `ADCC_A_INTC, {6'h0, ien, 1'b1});
        wr(`ADCC_A_INTC, {6'h0, ien, 1'b0});
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        fail_count = 0;
        checks_done = 0;
        cyc = 0;
        addr_i = 3'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        vin = {12'h5a3, 12'hfff, 12'h000, 12'h9c6};
        rst_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        rchk("ctrl_rst", `ADCC_A_CTRL, 8'h40);
        rchk("clk_rst", `ADCC_A_CLKSRC, 8'h00);
        rchk("unmapped", 3'h5, 8'h00);
        for (i = 0; i < 8; i++) begin
            wr(`ADCC_A_CTRL, {2'b00, i[2:0], 3'b000});
            @(negedge mclk_i);
            chk("pins", i >= 4 ? 16'hf : (16'h1 << i[1:0]) - 16'h1,
                {12'h0, analog_en_o});
            chk("pd", {15'h0, i == 0}, {15'h0, adc_pd_o});
        end
        wr(`ADCC_A_CLKSRC, 8'h05);
        rchk("clk_sel", `ADCC_A_CLKSRC, 8'h05);
        wr(`ADCC_A_INTC, 8'h02);
        for (i = 0; i < 4; i++) conv(i[1:0], 1'b1);
        wr(`ADCC_A_RHIGH, 8'h00);
        rchk("ro_res", `ADCC_A_RHIGH, 8'h5a);
        wr(`ADCC_A_CTRL, 8'ha1);
        wr(`ADCC_A_CTRL, 8'h21);
        repeat (100) @(posedge mclk_i);
        wr(`ADCC_A_CTRL, 8'ha1);
        repeat (400) @(posedge mclk_i);
        rchk("abort_flag", `ADCC_A_INTC, 8'h02);
        rchk("abort_res", `ADCC_A_RHIGH, 8'h5a);
        wr(`ADCC_A_INTC, 8'h00);
        conv(2'd1, 1'b0);
        results;
    end
endmodule

bind adcc_ctrl adcc_ctrl_chk #(.RES_BITS(RES_BITS)) u_adcc_ctrl_chk (
    .mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .cmp_i, .ch_sel_o, .analog_en_o, .adc_pd_o, .conv_rst_o,
    .dac_o, .irq_o);
`default_nettype wire
